// ### hw/servo_monitor_map.svh
// Remote bit positions, timing counts and reset values of the
// servo remote status and monitor block.
// Assumes the includer uses these only as constants.
`ifndef SERVO_MONITOR_MAP_SVH
`define SERVO_MONITOR_MAP_SVH

// ==========================================================
// Remote bit positions in the 64-bit remote bit images
`define RBIT_MON_REQ 6'd8
`define RBIT_MON_DONE 6'd8
`define RBIT_TROUBLE_1ST 6'd26
`define RBIT_TROUBLE_2ST 6'd58
`define RBIT_READY_1ST 6'd27
`define RBIT_READY_2ST 6'd59
`define RBIT_RESET_REQ_1ST 6'd26
`define RBIT_RESET_REQ_2ST 6'd58

// ==========================================================
// Read register indices
`define RWR_MON1 3'd0
`define RWR_MON2_1ST 3'd1
`define RWR_MON1_HI_2ST 3'd1
`define RWR_MON2_2ST 3'd5
`define RWR_MON2_HI_2ST 3'd6

// ==========================================================
// Reset values and timing
`define RWR_RESET 16'h0000
`define CLK_HZ 10000000
`define TROUBLE_CLEAR_MS 1500

`endif

// ### hw/servo_monitor_pkg.sv
// Types shared by the servo remote status and monitor block.
// Assumes servo_monitor_map.svh supplies the numeric constants.
package servo_monitor_pkg;

    // One-hot monitor handshake states
    typedef enum logic [1:0] {
        MON_IDLE = 2'b01,
        MON_DONE = 2'b10
    } mon_state_t;

    // Both monitor codes written by the master
    typedef struct packed {
        logic [15:0] code2;
        logic [15:0] code1;
    } monitor_code_in_t;

    // Status data answered for both codes, 32 bits each
    typedef struct packed {
        logic [31:0] data2;
        logic [31:0] data1;
    } status_data_t;

endpackage

// ### hw/servo_remote_status_monitor.sv
// Remote status bits and monitor request handshake of a servo
// driver fieldbus slave, held in the remote bit and register images.
// Assumes the fieldbus engine refreshes the images synchronously to
// ref_clk and the driver core answers status lookups combinationally.
// Assumes two_stations is static while the master is on line, and
// that the master drops its request for a cycle between requests.
//
// Summary of operation
// - Trouble flag set when protection trips power
// - Trouble flag clears about 1.5 s after power-on
// - Ready flag on, off at a latched alarm or a reset request, not during the power-on hold
// - Request loads first data, done raises together
// - One station: second data in read word 1
// - Two stations: second data in read word 5
// - Two stations: 32-bit upper halves in words 1 and 6
`timescale 1ns/100ps
`include "servo_monitor_map.svh"

module servo_remote_status_monitor #(
    parameter int unsigned TROUBLE_CLEAR_CYCLES =
        (`CLK_HZ / 1000) * `TROUBLE_CLEAR_MS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    // High when two stations are occupied
    input wire logic two_stations,
    // Protective circuit has shut off the power stage
    input wire logic protect_trip,
    // Remote input bit image written by the master
    input wire logic [63:0] ry_bits,
    // Remote input registers written by the master
    input wire servo_monitor_pkg::monitor_code_in_t monitor_code_in,
    // Status lookup towards the driver core
    output servo_monitor_pkg::monitor_code_in_t status_code,
    input wire servo_monitor_pkg::status_data_t status_data,
    // Remote output bit image read by the master
    output logic [63:0] rx_bits,
    // Remote output registers read by the master
    output logic [7:0][15:0] monitor_data_out,
    // Loose copies of the flags
    output logic trouble_flag,
    output logic comm_ready_flag,
    output logic monitor_done_bit
);

    // ======================================================
    // Counter width for the power-on trouble hold; one spare count
    // keeps the last compare value inside the counter's range
    localparam int unsigned HOLD_W = $clog2(TROUBLE_CLEAR_CYCLES + 1);

    // Pick a bit position by station occupancy
    function automatic logic [5:0] pick_pos(
        input logic two,
        input logic [5:0] one_pos,
        input logic [5:0] two_pos
    );
        pick_pos = two ? two_pos : one_pos;
    endfunction

    // Place both answers in the read words by station occupancy
    function automatic logic [7:0][15:0] place_words(
        input logic two,
        input logic [7:0][15:0] words,
        input servo_monitor_pkg::status_data_t data
    );
        logic [7:0][15:0] placed;
        placed = words;
        placed[`RWR_MON1] = data.data1[15:0];
        if (two) begin
            placed[`RWR_MON1_HI_2ST] = data.data1[31:16];
            placed[`RWR_MON2_2ST] = data.data2[15:0];
            placed[`RWR_MON2_HI_2ST] = data.data2[31:16];
        end else begin
            placed[`RWR_MON2_1ST] = data.data2[15:0];
        end
        return placed;
    endfunction

    // ======================================================
    // Request bits decoded from the master's bit image
    logic monitor_request_bit;
    logic reset_request;

    // Request bits at their occupancy dependent positions; the
    // monitor request sits at the same bit in both layouts
    always_comb begin
        monitor_request_bit = ry_bits[`RBIT_MON_REQ];
        reset_request = ry_bits[pick_pos(two_stations,
            `RBIT_RESET_REQ_1ST, `RBIT_RESET_REQ_2ST)];
    end

    // ======================================================
    // Power-on trouble hold
    // Masks nothing: it keeps trouble shown while the drive settles,
    // so the master never reads a clean state too early.
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic power_hold;
    logic next_power_hold;

    // Count edges until the hold runs out, then stop
    always_comb begin
        next_hold_cnt = hold_cnt;
        next_power_hold = power_hold;
        if (power_hold) begin
            if (hold_cnt == HOLD_W'(TROUBLE_CLEAR_CYCLES - 1)) begin
                next_power_hold = 1'b0;
            end else begin
                next_hold_cnt = hold_cnt + HOLD_W'(1);
            end
        end
    end

    // Hold registers; the hold is on from reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt <= '0;
            power_hold <= 1'b1;
        end else begin
            hold_cnt <= next_hold_cnt;
            power_hold <= next_power_hold;
        end
    end

    // ======================================================
    // Trouble and ready flags
    logic alarm;
    logic next_alarm;
    logic next_trouble_flag;
    logic next_comm_ready_flag;

    // Latched alarm and flag values
    // A trip and a reset request in one cycle keep the alarm set,
    // so a request can never hide a live trip from the master.
    always_comb begin
        next_alarm = alarm;
        if (protect_trip) begin
            next_alarm = 1'b1;
        end else if (reset_request) begin
            next_alarm = 1'b0;
        end
        next_trouble_flag = next_alarm | next_power_hold;
        next_comm_ready_flag = ~next_alarm & ~reset_request;
    end

    // Flag registers; ready is on from power-on
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alarm <= 1'b0;
            trouble_flag <= 1'b1;
            comm_ready_flag <= 1'b1;
        end else begin
            alarm <= next_alarm;
            trouble_flag <= next_trouble_flag;
            comm_ready_flag <= next_comm_ready_flag;
        end
    end

    // ======================================================
    // Monitor request handshake
    servo_monitor_pkg::mon_state_t mon_state;
    servo_monitor_pkg::mon_state_t next_mon_state;
    logic [7:0][15:0] next_monitor_data_out;
    logic next_monitor_done_bit;

    // Codes pass straight to the core for lookup; only the answer
    // present at the request edge is latched, so code changes
    // while done stands leave the read words alone.
    assign status_code = monitor_code_in;

    // Capture answers and raise done in the same cycle
    always_comb begin
        next_mon_state = mon_state;
        next_monitor_data_out = monitor_data_out;
        next_monitor_done_bit = monitor_done_bit;
        case (mon_state)
            servo_monitor_pkg::MON_IDLE: begin
                if (monitor_request_bit) begin
                    next_monitor_data_out = place_words(two_stations,
                        monitor_data_out, status_data);
                    next_monitor_done_bit = 1'b1;
                    next_mon_state = servo_monitor_pkg::MON_DONE;
                end
            end
            servo_monitor_pkg::MON_DONE: begin
                if (!monitor_request_bit) begin
                    next_monitor_done_bit = 1'b0;
                    next_mon_state = servo_monitor_pkg::MON_IDLE;
                end
            end
            default: begin
                // Stray state code: drop done and wait for a request
                next_monitor_done_bit = 1'b0;
                next_mon_state = servo_monitor_pkg::MON_IDLE;
            end
        endcase
    end

    // Handshake registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mon_state <= servo_monitor_pkg::MON_IDLE;
            monitor_data_out <= {8{`RWR_RESET}};
            monitor_done_bit <= 1'b0;
        end else begin
            mon_state <= next_mon_state;
            monitor_data_out <= next_monitor_data_out;
            monitor_done_bit <= next_monitor_done_bit;
        end
    end

    // ======================================================
    // Remote output bit image from the flag registers; occupancy
    // only moves the flags, so it must not change while on line
    always_comb begin
        rx_bits = '0;
        rx_bits[`RBIT_MON_DONE] = monitor_done_bit;
        rx_bits[pick_pos(two_stations, `RBIT_TROUBLE_1ST,
            `RBIT_TROUBLE_2ST)] = trouble_flag;
        rx_bits[pick_pos(two_stations, `RBIT_READY_1ST,
            `RBIT_READY_2ST)] = comm_ready_flag;
    end

endmodule

// ### tb/servo_remote_status_monitor_monitor.sv
// Checker of the status flags and monitor handshake.
// Assumes binding into servo_remote_status_monitor.
`timescale 1ns/100ps
module servo_remote_status_monitor_monitor (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic two_stations,
    input wire logic protect_trip,
    input wire logic [63:0] ry_bits,
    input wire servo_monitor_pkg::status_data_t status_data,
    input wire logic [7:0][15:0] monitor_data_out,
    input wire logic trouble_flag,
    input wire logic comm_ready_flag,
    input wire logic monitor_done_bit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Flags follow trip and reset request, handshake follows request
    property p_trip; protect_trip |=> trouble_flag; endproperty
    a_trip: assert property (p_trip) else $error("no trouble");
    property p_rdy; protect_trip || ry_bits[two_stations ? 58 : 26]
        |=> !comm_ready_flag; endproperty
    a_rdy: assert property (p_rdy) else $error("ready held");
    property p_load; $rose(ry_bits[8]) |=> monitor_done_bit &&
        monitor_data_out[0] == $past(status_data.data1[15:0]); endproperty
    a_load: assert property (p_load) else $error("bad load");
    property p_quiet; !ry_bits[8] && !monitor_done_bit
        |=> !monitor_done_bit; endproperty
    a_quiet: assert property (p_quiet) else $error("done unasked");
    property p_keep; monitor_done_bit && ry_bits[8] |=> monitor_done_bit;
    endproperty
    a_keep: assert property (p_keep) else $error("done lost");
    property p_drop; monitor_done_bit && !ry_bits[8] |=> !monitor_done_bit;
    endproperty
    a_drop: assert property (p_drop) else $error("done stuck");
    property p_one; $rose(ry_bits[8]) && !two_stations |=>
        monitor_data_out[1] == $past(status_data.data2[15:0]); endproperty
    a_one: assert property (p_one) else $error("bad word 1");
    property p_two; $rose(ry_bits[8]) && two_stations |=>
        monitor_data_out[1] == $past(status_data.data1[31:16]) &&
        monitor_data_out[6:5] == $past(status_data.data2); endproperty
    a_two: assert property (p_two) else $error("bad words");
    c_two: cover property ($rose(ry_bits[8]) && two_stations);
    c_trip: cover property (protect_trip);
    c_rst: cover property (ry_bits[two_stations ? 58 : 26]);
endmodule
bind servo_remote_status_monitor
    servo_remote_status_monitor_monitor mon_u (.*);

// ### tb/plc_master_model.sv
// Fieldbus master model: request bits and monitor codes.
// Assumes the device answers one cycle after the request.
`timescale 1ns/100ps
module plc_master_model (
    input wire logic ref_clk,
    input wire logic monitor_done_bit,
    output logic [63:0] ry_bits,
    output servo_monitor_pkg::monitor_code_in_t monitor_code_in
);
    // Idle master
    initial ry_bits = 64'h0000_0000_0000_0000;
    initial monitor_code_in = 32'h0000_0000;
    // Reset request bit, set just after an edge
    task automatic set_reset_request(input int pos, input logic v);
        ry_bits[pos] = v;
    endtask
    // Codes first, request held past done, then dropped
    task automatic monitor(input logic [31:0] k, input int hold,
        output logic ok);
        monitor_code_in = k;
        @(posedge ref_clk);
        #1 ry_bits[8] = 1'b1;
        @(posedge ref_clk);
        #1 ok = monitor_done_bit;
        // New codes while done stands must not be taken
        monitor_code_in = ~k;
        repeat (hold + 1) @(posedge ref_clk);
        #1 ok &= monitor_done_bit;
        ry_bits[8] = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 ok &= !monitor_done_bit;
    endtask
endmodule

// ### tb/servo_remote_status_monitor_tb.sv
// Bench of the status flags and monitor handshake.
// Assumes package, design, checker and master model.
`timescale 1ns/100ps
module servo_remote_status_monitor_tb;
    logic ref_clk = 1'b0, rstn = 1'b0, two_stations = 1'b0;
    logic protect_trip = 1'b0, ok, trouble_flag, comm_ready_flag;
    logic monitor_done_bit;
    logic [3:0] st;
    logic [63:0] ry_bits, rx_bits, w;
    logic [7:0][15:0] monitor_data_out;
    logic [31:0] seed = 32'h0000_9303, c, e1, e2;
    servo_monitor_pkg::monitor_code_in_t monitor_code_in, status_code;
    servo_monitor_pkg::status_data_t status_data;
    localparam int HOLD = 20;
    int failures = 0, total_checks = 0, cyc = 0, tp;
    // Core answers, flag and word views
    assign status_data = {ans(status_code.code2), ans(status_code.code1)};
    assign st = {rx_bits[tp+:2], trouble_flag, comm_ready_flag};
    assign w = {monitor_data_out[6:5], monitor_data_out[1:0]};
    servo_remote_status_monitor #(.TROUBLE_CLEAR_CYCLES(HOLD)) dut_u (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .two_stations(two_stations),
        .protect_trip(protect_trip),
        .ry_bits(ry_bits),
        .monitor_code_in(monitor_code_in),
        .status_code(status_code),
        .status_data(status_data),
        .rx_bits(rx_bits),
        .monitor_data_out(monitor_data_out),
        .trouble_flag(trouble_flag),
        .comm_ready_flag(comm_ready_flag),
        .monitor_done_bit(monitor_done_bit)
    );
    // Master watches done through its remote bit image
    plc_master_model plc_u (
        .ref_clk(ref_clk),
        .monitor_done_bit(rx_bits[8]),
        .ry_bits(ry_bits),
        .monitor_code_in(monitor_code_in)
    );
    // Clock and hang guard
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 3000) results(1'b1);
    function automatic logic [31:0] ans(input logic [15:0] k);
        return {k ^ 16'h5A5A, ~k};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results(input logic late);
        failures += late;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Per mode: reset, flag walk, then monitor requests
    initial begin
        for (int m = 0; m < 2; m++) begin
            @(posedge ref_clk);
            #1 rstn = 1'b0;
            two_stations = m[0];
            tp = m ? 58 : 26;
            repeat (12) @(posedge ref_clk);
            #1 rstn = 1'b1;
            check(trouble_flag, 1'b1);
            repeat (HOLD - 1) @(posedge ref_clk);
            #1 check(st, 4'hF);
            @(posedge ref_clk);
            #1 check(st, 4'h9);
            protect_trip = 1'b1;
            @(posedge ref_clk);
            #1 check(st, 4'h6);
            plc_u.set_reset_request(tp, 1'b1);
            @(posedge ref_clk);
            #1 check(st, 4'h6);
            protect_trip = 1'b0;
            repeat (2) @(posedge ref_clk);
            #1 check(st, 4'h0);
            plc_u.set_reset_request(tp, 1'b0);
            repeat (2) @(posedge ref_clk);
            #1 check(st, 4'h9);
            for (int i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                c = i == 0 ? 32'hFFFF_0000 : seed;
                plc_u.monitor(c, i % 3, ok);
                check({ok, monitor_done_bit}, 2'b10);
                e1 = ans(c[15:0]);
                e2 = ans(c[31:16]);
                if (m) check(w, {e2, e1});
                else check(w, {32'h0, e2[15:0], e1[15:0]});
            end
        end
        results(1'b0);
    end
endmodule
